// File: design/ter_recorder.sv
// Purpose: per-channel event detect, first/last timestamp, event count
// Assumes: rtc_count_in is on clk_in; wake event inputs are asynchronous pins
// Notes:   counter saturates; wake pulses only for enabled channels
`timescale 1ns/10ps

module ter_recorder (
	input  wire logic                                   clk_in,
	input  wire logic                                   rst_n_in,
	input  wire logic [ter_pkg::NUM_CH-1:0]             wake_event_input_in,
	input  wire logic [ter_pkg::RTC_W-1:0]              rtc_count_in,
	input  wire logic                                   sys_running_in,
	input  wire logic [ter_pkg::NUM_CH-1:0]             irq_enable_in,
	input  wire logic [ter_pkg::NUM_CH-1:0]             irq_clear_in,
	input  wire logic [ter_pkg::NUM_CH-1:0]             wake_enable_in,
	input  wire logic [ter_pkg::NUM_CH-1:0]             record_clear_in,
	output logic [ter_pkg::NUM_CH*ter_pkg::RTC_W-1:0]   first_stamp_out,
	output logic [ter_pkg::NUM_CH*ter_pkg::RTC_W-1:0]   last_stamp_out,
	output logic [ter_pkg::NUM_CH*ter_pkg::CNT_W-1:0]   event_count_out,
	output logic [ter_pkg::NUM_CH-1:0]                  seen_out,
	output logic [ter_pkg::NUM_CH-1:0]                  irq_status_out,
	output logic                                        irq_out,
	output logic                                        wake_out
);
	logic [ter_pkg::NUM_CH-1:0] sync1_ff;
	logic [ter_pkg::NUM_CH-1:0] sync2_ff;
	logic [ter_pkg::NUM_CH-1:0] prev_ff;
	logic [ter_pkg::NUM_CH-1:0] armed_ff;
	logic [ter_pkg::NUM_CH-1:0] irq_ff;
	logic                       wake_ff;
	wire  [ter_pkg::NUM_CH-1:0] event_hit;
	wire  [ter_pkg::NUM_CH-1:0] nxt_irq;

	// two-stage synchroniser; stage one read only by stage two
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= wake_event_input_in;
			sync2_ff <= sync1_ff;
		end
	end

	// first sample after reset only arms the edge detector
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_ff  <= '0;
			armed_ff <= '0;
		end else begin
			prev_ff  <= sync2_ff;
			armed_ff <= '1;
		end
	end

	assign event_hit = (sync2_ff ^ prev_ff) & armed_ff;
	// set beats clear in the same cycle
	assign nxt_irq   = (irq_ff & ~irq_clear_in) | (event_hit & irq_enable_in & {ter_pkg::NUM_CH{sys_running_in}});

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_ff  <= '0;
			wake_ff <= 1'b0;
		end else begin
			irq_ff  <= nxt_irq;
			wake_ff <= |(event_hit & wake_enable_in);
		end
	end

	assign irq_status_out = irq_ff;
	assign irq_out        = |irq_ff;
	assign wake_out       = wake_ff;

	genvar g;
	generate
		for (g = 0; g < ter_pkg::NUM_CH; g++) begin : g_ch
			logic [ter_pkg::RTC_W-1:0] first_ff;
			logic [ter_pkg::RTC_W-1:0] last_ff;
			logic [ter_pkg::CNT_W-1:0] cnt_ff;
			logic                      seen_ff;
			wire                       take_first;
			wire                       bump;

			assign take_first = event_hit[g] & (~seen_ff | record_clear_in[g]);
			assign bump       = event_hit[g] & (cnt_ff != ter_pkg::CNT_MAX);

			// an event in the clear cycle starts a fresh record
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					first_ff <= ter_pkg::TS_RESET;
					last_ff  <= ter_pkg::TS_RESET;
					cnt_ff   <= ter_pkg::CNT_RESET;
					seen_ff  <= 1'b0;
				end else begin
					if (take_first)
						first_ff <= rtc_count_in;
					else if (record_clear_in[g])
						first_ff <= ter_pkg::TS_RESET;
					if (event_hit[g])
						last_ff <= rtc_count_in;
					else if (record_clear_in[g])
						last_ff <= ter_pkg::TS_RESET;
					if (record_clear_in[g])
						cnt_ff <= event_hit[g] ? 8'h01 : ter_pkg::CNT_RESET;
					else if (bump)
						cnt_ff <= cnt_ff + 8'h01;
					seen_ff <= event_hit[g] | (seen_ff & ~record_clear_in[g]);
				end
			end

			assign first_stamp_out[g*ter_pkg::RTC_W +: ter_pkg::RTC_W] = first_ff;
			assign last_stamp_out[g*ter_pkg::RTC_W +: ter_pkg::RTC_W]  = last_ff;
			assign event_count_out[g*ter_pkg::CNT_W +: ter_pkg::CNT_W] = cnt_ff;
			assign seen_out[g]                                         = seen_ff;
		end
	endgenerate
endmodule : ter_recorder

// File: design/ter_pkg.sv
// Purpose: constants for the tamper event recorder
// Assumes: rtc count width and counter width chosen here
// Notes:   no software registers; all record state leaves on ports
package ter_pkg;
	localparam int unsigned NUM_CH    = 3;
	localparam int unsigned RTC_W     = 32;
	localparam int unsigned CNT_W     = 8;
	localparam logic [7:0]  CNT_MAX   = 8'hff;
	localparam logic [31:0] TS_RESET  = 32'h0000_0000;
	localparam logic [7:0]  CNT_RESET = 8'h00;
endpackage : ter_pkg

// File: sim/ter_sensor.sv
// Purpose: sensor pins
// Assumes: a level flips one edge after a request
// Notes: levels start low
`timescale 1ns/10ps
module ter_sensor (input wire logic clk_in, input wire logic [2:0] flip_in, output logic [2:0] level_out = 3'h0);
	always @(posedge clk_in) level_out <= level_out ^ flip_in;
endmodule : ter_sensor

// File: sim/ter_recorder_props.sv
// Purpose: recorder port checks
// Assumes: outputs move 3 edges after a pin sample
// Notes: channel 0 in detail
`timescale 1ns/10ps
module ter_recorder_props (input wire logic clk_in, rst_n_in, irq_out, wake_out,
	input wire logic [2:0] wake_event_input_in, irq_clear_in, record_clear_in, seen_out, irq_status_out,
	input wire logic [31:0] rtc_count_in, input wire logic [95:0] first_stamp_out,
	input wire logic [23:0] event_count_out);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_or; irq_out == |irq_status_out; endproperty
	a_or: assert property (p_or) else $error("irq");
	property p_sn; $rose(wake_event_input_in[0]) |-> ##3 seen_out[0]; endproperty
	a_sn: assert property (p_sn) else $error("seen");
	property p_cs; $rose(seen_out[0]) |-> $past(wake_event_input_in[0], 3) != $past(wake_event_input_in[0], 4); endproperty
	a_cs: assert property (p_cs) else $error("cause");
	property p_ct; $changed(event_count_out[7:0]) && !$past(record_clear_in[0])
		|-> event_count_out[7:0] == $past(event_count_out[7:0]) + 8'h01; endproperty
	a_ct: assert property (p_ct) else $error("count");
	property p_ts; $rose(seen_out[0]) |-> first_stamp_out[31:0] == $past(rtc_count_in); endproperty
	a_ts: assert property (p_ts) else $error("stamp");
	property p_hd; seen_out[0] && !record_clear_in[0] |=> $stable(first_stamp_out[31:0]); endproperty
	a_hd: assert property (p_hd) else $error("first");
	property p_sk; irq_status_out[0] && !irq_clear_in[0] |=> irq_status_out[0]; endproperty
	a_sk: assert property (p_sk) else $error("sticky");
	property p_wk; wake_out |-> $past(wake_event_input_in, 3) != $past(wake_event_input_in, 4); endproperty
	a_wk: assert property (p_wk) else $error("wake");
endmodule : ter_recorder_props
bind ter_recorder ter_recorder_props i_props (.*);

// File: sim/ter_recorder_tb.sv
// Purpose: recorder bench
// Assumes: rtc counts clock edges
// Notes: pin moves one edge after request
`timescale 1ns/10ps
module ter_recorder_tb;
	logic clk_in = 0, rst_n_in = 0, s = 0, io, wo, wk = 0;
	logic [2:0] p = 0, ic = 0, rc = 0, w, sn, q;
	logic [31:0] r = 0, a, b;
	logic [95:0] f, l;
	logic [23:0] n;
	int n_mismatch = 0, compares = 0, c = 0;
	ter_sensor i_sen (.clk_in, .flip_in(p), .level_out(w));
	ter_recorder i_dut (.clk_in, .rst_n_in, .wake_event_input_in(w), .rtc_count_in(r), .sys_running_in(s),
		.irq_enable_in(3'h7), .irq_clear_in(ic), .wake_enable_in(3'h7), .record_clear_in(rc), .first_stamp_out(f),
		.last_stamp_out(l), .event_count_out(n), .seen_out(sn), .irq_status_out(q), .irq_out(io), .wake_out(wo));
	initial forever #25 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		r <= r + 32'h1;
		c <= c + 1;
		if (c == 300) begin n_mismatch++; conclude; end
	end
	task chk(string m, logic [31:0] e, v); compares++;
		if (v !== e) begin n_mismatch++; $display("[ERR] %s exp %h got %h", m, e, v); end
	endtask : chk
	task conclude; $display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude
	task ev(int k, output logic [31:0] e); @(posedge clk_in); e = r + 32'h4; p <= 3'h1 << k;
		@(posedge clk_in); p <= 3'h0; repeat (3) @(posedge clk_in); #1;
		wk = wo; // wake pulse stands one cycle only
		@(posedge clk_in); #1;
	endtask : ev
	task t_quiet; ev(0, a);
		chk("cnt0", 1, n[7:0]);
		chk("first0", a, f[31:0]);
		chk("irq0", 0, q[0]);
		chk("wake0", 1, wk);
		chk("seen0", 1, sn[0]);
	endtask : t_quiet
	task t_run; @(posedge clk_in); s <= 1; ev(0, b);
		chk("last0", b, l[31:0]);
		chk("keep0", a, f[31:0]);
		chk("irq", 1, io);
		ev(2, b); chk("cnt2", 1, n[23:16]);
		chk("first2", b, f[95:64]);
		chk("last2", b, l[95:64]);
		chk("wake2", 1, wk);
	endtask : t_run
	task t_clr; @(posedge clk_in); ic <= 3'h7; rc <= 3'h1; @(posedge clk_in); ic <= 0; rc <= 0; @(posedge clk_in); #1;
		chk("irqc", 0, io);
		chk("cntc", 0, n[7:0]);
		chk("seenc", 0, sn[0]);
		chk("firstc", 0, f[31:0]);
	endtask : t_clr
	initial begin repeat (2) @(posedge clk_in); rst_n_in <= 1; t_quiet; t_run; t_clr; conclude; end
endmodule : ter_recorder_tb
